// ### logic/hic_config.sv
// init block fetch, mode word decode and modem pin control
//
// Contract
// [RULE1] modem-ready dir 0: pin input, bit reads pin
// [RULE2] modem-ready dir 1: pin drives written bit
// [RULE3] terminal-ready bit mirrors or drives its pin
// [RULE4] init fetches part now, rest on demand
// [RULE5] mode, addresses, length, scaler, timer at +0..+10
// [RULE6] protocol, timer, ring words at +12..+22
// [RULE7] descriptors +24/+32, status +40, counters +44
// [RULE8] mode word field layout
// [RULE9] at least spacing flags between sent frames
// [RULE10] spacing never restricts received frames
// [RULE11] handshake: spacing flags minus one after CTS
// [RULE12] force plus filter: control field two octets
// [RULE13] force plus filter: address field two octets
// [RULE14] extract disable: address/control kept as data
// [RULE15] host keeps extract disable 1 unless filtering
// [RULE16] control filtering needs filter, no disable, no promiscuous
// [RULE17] address filtering needs filter, no disable, no promiscuous
`timescale 1ns/1ps
`default_nettype none
module hic_config
  import hic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // init command and memory port
  input wire logic init_cmd,
  input wire logic [23:0] init_block_base,
  output logic mem_req,
  output logic [23:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic init_done,
  // deferred word requests
  input wire logic word_req,
  input wire logic [3:0] word_index,
  output logic word_valid,
  output logic [15:0] word_data,
  // cached parameter read
  input wire logic [3:0] param_sel,
  output logic [15:0] param_data,
  // modem control register
  input wire logic csr_wr,
  input wire logic [3:0] csr_wdata,
  output logic [3:0] csr_rdata,
  // modem-ready / clear-to-send pin
  input wire logic modem_ready_in,
  output logic modem_ready_out,
  output logic modem_ready_oe,
  // terminal-ready / request-to-send pin
  input wire logic terminal_ready_in,
  output logic terminal_ready_out,
  output logic terminal_ready_oe,
  // promiscuous receive and transmit spacing
  input wire logic promiscuous_receive,
  input wire logic rts_cts_mode,
  input wire logic tx_frame_end,
  input wire logic tx_flag_sent,
  output logic tx_start_ok,
  // decoded mode
  output logic [5:0] min_flag_count,
  output logic ext_control_filter_active,
  output logic ext_address_filter_active,
  output logic ctrl_two_octets,
  output logic addr_two_octets,
  output logic addr_ctrl_extract_disable,
  output logic rx_check_disable,
  output logic tx_check_disable,
  output logic check_width_select,
  output logic [2:0] loopback_select
);
  import hic_pkg::*;

  // fetch sequencer state
  hic_state_t state, next_state;
  logic [23:0] base, next_base; // block base captured at init
  logic [3:0] idx, next_idx; // eager word index
  logic next_mem_req;
  logic [23:0] next_mem_addr;
  logic next_init_done;
  logic next_word_valid;
  logic [15:0] next_word_data;
  logic store_wr; // cache write strobe
  logic [15:0] mode, next_mode; // operating_mode_word

  // fetch sequencer: eager part on init, the rest one word per request
  always_comb begin
    next_state = state;
    next_base = base;
    next_idx = idx;
    next_mem_req = mem_req;
    next_mem_addr = mem_addr;
    next_init_done = init_done;
    next_word_valid = 1'b0;
    next_word_data = word_data;
    next_mode = mode;
    store_wr = 1'b0;
    case (state)
      HIC_IDLE: begin
        if (init_cmd) begin
          // start at the mode word, offset zero
          next_base = init_block_base; // [RULE5]
          next_idx = 4'h0;
          next_mem_addr = init_block_base + OFS_MODE; // [RULE5]
          next_mem_req = 1'b1;
          next_init_done = 1'b0;
          next_state = HIC_EAGER; // [RULE4]
        end else if (word_req && init_done) begin
          // descriptors, status buffer and counters only when needed
          next_mem_addr = base + OFS_XCHG_TX_DESC + {20'h0_0000, word_index} * WORD_STEP; // [RULE4] [RULE7]
          next_mem_req = 1'b1;
          next_state = HIC_DEFER;
        end
      end
      HIC_EAGER: begin
        if (mem_ack) begin
          store_wr = 1'b1;
          if (idx == 4'h0) begin
            next_mode = mem_rdata; // [RULE8]
          end
          if (idx == EAGER_LAST) begin
            // ring words at +22 are the last fetched at once
            next_mem_req = 1'b0;
            next_init_done = 1'b1; // [RULE6]
            next_state = HIC_IDLE;
          end else begin
            next_idx = idx + 4'h1;
            next_mem_addr = mem_addr + WORD_STEP; // [RULE5] [RULE6]
          end
        end
      end
      HIC_DEFER: begin
        if (mem_ack) begin
          next_mem_req = 1'b0;
          next_word_valid = 1'b1;
          next_word_data = mem_rdata;
          next_state = HIC_IDLE;
        end
      end
      default: begin
        next_state = HIC_IDLE;
        next_mem_req = 1'b0;
      end
    endcase
  end

  // fetch sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= HIC_IDLE;
      base <= 24'h00_0000;
      idx <= 4'h0;
      mem_req <= 1'b0;
      mem_addr <= 24'h00_0000;
      init_done <= 1'b0;
      word_valid <= 1'b0;
      word_data <= 16'h0000;
      mode <= MODE_RESET;
    end else begin
      state <= next_state;
      base <= next_base;
      idx <= next_idx;
      mem_req <= next_mem_req;
      mem_addr <= next_mem_addr;
      init_done <= next_init_done;
      word_valid <= next_word_valid;
      word_data <= next_word_data;
      mode <= next_mode;
    end
  end

  // cache of the eager words, read by param_sel
  hic_word_store #(.DEPTH(16), .WIDTH(16)) u_store (
    .clk(clk),
    .rst(rst),
    .wr_en(store_wr),
    .wr_addr(idx),
    .wr_data(mem_rdata),
    .rd_addr(param_sel),
    .rd_data(param_data)
  );

  // modem pins: two flops before anything looks at them
  logic [1:0] mr_sync, tr_sync;
  logic [3:0] modem, next_modem; // written dir and value bits
  logic [3:0] next_csr_rdata;
  logic next_mr_out, next_mr_oe, next_tr_out, next_tr_oe;

  // modem register writes and read-back
  always_comb begin
    next_modem = modem;
    if (csr_wr) begin
      next_modem = csr_wdata;
    end
    next_csr_rdata = next_modem;
    // input direction: bit shows the live pin instead of the stored value
    if (!next_modem[BIT_MODEM_READY_DIR]) begin
      next_csr_rdata[BIT_MODEM_READY] = mr_sync[1]; // [RULE1]
    end
    if (!next_modem[BIT_TERMINAL_READY_DIR]) begin
      next_csr_rdata[BIT_TERMINAL_READY] = tr_sync[1]; // [RULE3]
    end
    // output direction: drive the written bit
    next_mr_oe = next_modem[BIT_MODEM_READY_DIR]; // [RULE1] [RULE2]
    next_mr_out = next_modem[BIT_MODEM_READY]; // [RULE2]
    next_tr_oe = next_modem[BIT_TERMINAL_READY_DIR]; // [RULE3]
    next_tr_out = next_modem[BIT_TERMINAL_READY]; // [RULE3]
  end

  // modem registers and pin synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mr_sync <= 2'b00;
      tr_sync <= 2'b00;
      modem <= MODEM_RESET;
      csr_rdata <= 4'h0;
      modem_ready_out <= 1'b0;
      modem_ready_oe <= 1'b0;
      terminal_ready_out <= 1'b0;
      terminal_ready_oe <= 1'b0;
    end else begin
      mr_sync <= {mr_sync[0], modem_ready_in};
      tr_sync <= {tr_sync[0], terminal_ready_in};
      modem <= next_modem;
      csr_rdata <= next_csr_rdata;
      modem_ready_out <= next_mr_out;
      modem_ready_oe <= next_mr_oe;
      terminal_ready_out <= next_tr_out;
      terminal_ready_oe <= next_tr_oe;
    end
  end

  // mode decode; a bad host setting of extract disable is not corrected here
  logic [5:0] next_min_flag_count;
  logic next_ctrl_filter, next_addr_filter, next_ctrl_two, next_addr_two;

  // filter enables and forced field lengths
  always_comb begin
    next_min_flag_count = hic_flags(mode[MFS_HI:MFS_LO]); // [RULE8] [RULE9]
    // extract disable passes address and control as plain data
    next_ctrl_filter = mode[BIT_EXT_CONTROL_FILTER] && !mode[BIT_EXTRACT_DISABLE]
                       && !promiscuous_receive; // [RULE16] [RULE14]
    next_addr_filter = mode[BIT_EXT_ADDRESS_FILTER] && !mode[BIT_EXTRACT_DISABLE]
                       && !promiscuous_receive; // [RULE17] [RULE14]
    next_ctrl_two = next_ctrl_filter && mode[BIT_EXT_CONTROL_FORCE]; // [RULE12]
    next_addr_two = next_addr_filter && mode[BIT_EXT_ADDRESS_FORCE]; // [RULE13]
  end

  // decoded outputs held in flops; none of them feed the receive path
  // with a spacing limit, so close frames are received as usual [RULE10]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      min_flag_count <= 6'd2;
      ext_control_filter_active <= 1'b0;
      ext_address_filter_active <= 1'b0;
      ctrl_two_octets <= 1'b0;
      addr_two_octets <= 1'b0;
      addr_ctrl_extract_disable <= 1'b1;
      rx_check_disable <= 1'b0;
      tx_check_disable <= 1'b0;
      check_width_select <= 1'b0;
      loopback_select <= 3'h0;
    end else begin
      min_flag_count <= next_min_flag_count;
      ext_control_filter_active <= next_ctrl_filter;
      ext_address_filter_active <= next_addr_filter;
      ctrl_two_octets <= next_ctrl_two;
      addr_two_octets <= next_addr_two;
      addr_ctrl_extract_disable <= mode[BIT_EXTRACT_DISABLE]; // [RULE14]
      rx_check_disable <= mode[BIT_RX_CHECK_DISABLE];
      tx_check_disable <= mode[BIT_TX_CHECK_DISABLE];
      check_width_select <= mode[BIT_CHECK_WIDTH];
      loopback_select <= mode[LOOP_HI:0];
    end
  end

  // transmit spacing: clear-to-send asserted when its pin is low and an input
  logic cts_low;
  assign cts_low = !modem[BIT_MODEM_READY_DIR] && !mr_sync[1];

  hic_flag_gap u_gap (
    .clk(clk),
    .rst(rst),
    .flags_needed(min_flag_count),
    .handshake(rts_cts_mode),
    .cts_low(cts_low),
    .frame_end(tx_frame_end),
    .flag_sent(tx_flag_sent),
    .start_ok(tx_start_ok)
  );
endmodule // hic_config
`default_nettype wire

// ### logic/hic_flag_gap.sv
// counts flags sent since the last frame end or clear-to-send assertion
`timescale 1ns/1ps
`default_nettype none
module hic_flag_gap (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] flags_needed,
  input wire logic handshake,
  input wire logic cts_low,
  input wire logic frame_end,
  input wire logic flag_sent,
  output logic start_ok
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic cts_prev;
  logic next_start_ok;
  logic [5:0] target;

  // count flags, restart at each frame end or at the fall of clear-to-send
  always_comb begin
    next_cnt = cnt;
    // closing flag of the last frame counts, so one fewer is needed
    target = handshake ? flags_needed - 6'd1 : flags_needed; // [RULE11]
    if (frame_end || (handshake && cts_low && !cts_prev)) begin
      next_cnt = 6'd0; // [RULE9] [RULE11]
    end else if (flag_sent && cnt != 6'h3F) begin
      next_cnt = cnt + 6'd1; // saturate, 63 is past every legal target
    end
    // start allowed only once enough flags are out
    next_start_ok = (next_cnt >= target) && (!handshake || cts_low); // [RULE9] [RULE11]
  end

  // counter and start permission
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 6'd0;
      cts_prev <= 1'b1; // matches cts_low after reset, no false fall
      start_ok <= 1'b0;
    end else begin
      cnt <= next_cnt;
      cts_prev <= cts_low;
      start_ok <= next_start_ok;
    end
  end
endmodule // hic_flag_gap
`default_nettype wire

// ### logic/hic_pkg.sv
// constants and decode table for the initialization block and mode word
package hic_pkg;
  // init block word offsets in bytes from the base address
  localparam logic [23:0] OFS_MODE = 24'h00_0000;
  localparam logic [23:0] OFS_RX_FRAME_ADDR = 24'h00_0002;
  localparam logic [23:0] OFS_TX_FRAME_ADDR = 24'h00_0004;
  localparam logic [23:0] OFS_MAX_FRAME_LENGTH = 24'h00_0006;
  localparam logic [23:0] OFS_SCALER = 24'h00_0008;
  localparam logic [23:0] OFS_ACK_TIMER = 24'h00_000A;
  localparam logic [23:0] OFS_PROTOCOL = 24'h00_000C;
  localparam logic [23:0] OFS_IDLE_PROBE_TIMER = 24'h00_000E;
  localparam logic [23:0] OFS_RX_RING_HI = 24'h00_0010;
  localparam logic [23:0] OFS_RX_RING_LO = 24'h00_0012;
  localparam logic [23:0] OFS_TX_RING_HI = 24'h00_0014;
  localparam logic [23:0] OFS_TX_RING_LO = 24'h00_0016;
  localparam logic [23:0] OFS_XCHG_TX_DESC = 24'h00_0018;
  localparam logic [23:0] OFS_XCHG_RX_DESC = 24'h00_0020;
  localparam logic [23:0] OFS_STATUS_BUF = 24'h00_0028;
  localparam logic [23:0] OFS_ERR_COUNTERS = 24'h00_002C;
  // words fetched at once on an init command (mode through tx ring low)
  localparam logic [3:0] EAGER_LAST = 4'hB;
  // byte step between words
  localparam logic [23:0] WORD_STEP = 24'h00_0002;
  // mode word field positions
  localparam int MFS_HI = 15;
  localparam int MFS_LO = 11;
  localparam int BIT_EXT_CONTROL_FORCE = 10;
  localparam int BIT_EXT_ADDRESS_FORCE = 9;
  localparam int BIT_EXTRACT_DISABLE = 8;
  localparam int BIT_EXT_CONTROL_FILTER = 7;
  localparam int BIT_EXT_ADDRESS_FILTER = 6;
  localparam int BIT_RX_CHECK_DISABLE = 5;
  localparam int BIT_TX_CHECK_DISABLE = 4;
  localparam int BIT_CHECK_WIDTH = 3;
  localparam int LOOP_HI = 2;
  // mode reset: transparent transfer, no loopback
  localparam logic [15:0] MODE_RESET = 16'h0100;
  // modem control register bit positions
  localparam int BIT_TERMINAL_READY_DIR = 3;
  localparam int BIT_MODEM_READY_DIR = 2;
  localparam int BIT_TERMINAL_READY = 1;
  localparam int BIT_MODEM_READY = 0;
  localparam logic [3:0] MODEM_RESET = 4'h0;

  // fetch sequencer states
  typedef enum logic [1:0] {
    HIC_IDLE,
    HIC_EAGER,
    HIC_DEFER
  } hic_state_t;

  // minimum spacing code to number of flags
  function automatic logic [5:0] hic_flags(input logic [4:0] code);
    logic [5:0] n;
    n = 6'h02;
    case (code)
      5'h01: n = 6'd1;   5'h00: n = 6'd2;   5'h02: n = 6'd4;   5'h04: n = 6'd6;
      5'h09: n = 6'd8;   5'h12: n = 6'd10;  5'h05: n = 6'd12;  5'h0B: n = 6'd14;
      5'h16: n = 6'd16;  5'h0C: n = 6'd18;  5'h19: n = 6'd20;  5'h13: n = 6'd22;
      5'h07: n = 6'd24;  5'h0F: n = 6'd26;  5'h1F: n = 6'd28;  5'h1E: n = 6'd30;
      5'h1C: n = 6'd32;  5'h18: n = 6'd34;  5'h11: n = 6'd36;  5'h03: n = 6'd38;
      5'h06: n = 6'd40;  5'h0D: n = 6'd42;  5'h1B: n = 6'd44;  5'h17: n = 6'd46;
      5'h0E: n = 6'd48;  5'h1D: n = 6'd50;  5'h1A: n = 6'd52;  5'h15: n = 6'd54;
      5'h0A: n = 6'd56;  5'h14: n = 6'd58;  5'h08: n = 6'd60;  5'h10: n = 6'd62;
      default: n = 6'd2;
    endcase
    return n;
  endfunction
endpackage

// ### logic/hic_word_store.sv
// small register file caching the eagerly fetched init block words
`timescale 1ns/1ps
`default_nettype none
module hic_word_store #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // elaboration check: every eager word needs its own entry
  if (DEPTH < 12 || WIDTH < 1) begin : g_bad_size
    $error("hic_word_store: depth must hold the eager words");
  end

  // storage array, no reset so it maps onto plain memory
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rd_data;

  // read data always leaves through a register
  always_comb begin
    next_rd_data = mem[rd_addr];
  end

  // write port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end
endmodule // hic_word_store
`default_nettype wire

// ### tb/hic_config_chk.sv
// port assertions for the config block
`timescale 1ns/1ps
`default_nettype none
module hic_config_chk
  import hic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic init_cmd,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic init_done,
  input wire logic word_req,
  input wire logic [3:0] word_index,
  input wire logic word_valid,
  input wire logic csr_wr,
  input wire logic [3:0] csr_wdata,
  input wire logic [3:0] csr_rdata,
  input wire logic modem_ready_in,
  input wire logic modem_ready_out,
  input wire logic modem_ready_oe,
  input wire logic terminal_ready_in,
  input wire logic terminal_ready_oe,
  input wire logic promiscuous_receive,
  input wire logic ext_control_filter_active,
  input wire logic addr_ctrl_extract_disable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic req_q, init_q, wreq_q; // strobes one cycle back
  logic [3:0] idx_q, acks; // word index asked, words answered since start
  logic [23:0] base_q; // base seen at the first eager read
  logic [15:0] mode_q; // mode word as delivered
  // follows the fetch from the bus side only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {req_q, init_q, wreq_q, idx_q, acks, base_q, mode_q} <= '0;
    end else begin
      req_q <= mem_req;
      init_q <= init_cmd;
      wreq_q <= word_req;
      idx_q <= word_index;
      if (mem_req && !req_q && init_q) begin
        base_q <= mem_addr;
        acks <= 4'h0;
      end else if (mem_ack) acks <= acks + 4'h1;
      if (mem_ack && !init_done && mem_addr == base_q) mode_q <= mem_rdata;
    end
  end
  a_modem_dir_follow: assert property (csr_wr |=> modem_ready_oe == $past(csr_wdata[2]))
    else $error("modem pin direction not taken from write");
  a_modem_out_bit: assert property (modem_ready_oe |-> modem_ready_out == csr_rdata[0])
    else $error("modem pin level differs from its bit");
  a_modem_pin_read: assert property ((!modem_ready_oe && $stable(modem_ready_in))[*3]
    ##0 !(csr_wr && csr_wdata[2])
    |=> csr_rdata[0] == $past(modem_ready_in)) else $error("modem bit not tracking pin");
  a_term_pin_read: assert property ((!terminal_ready_oe && $stable(terminal_ready_in))[*3]
    ##0 !(csr_wr && csr_wdata[3])
    |=> csr_rdata[1] == $past(terminal_ready_in)) else $error("terminal bit not tracking pin");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped or moved before ack");
  a_eager_count: assert property ($rose(init_done) |-> acks == 4'hC)
    else $error("init done without exactly twelve words");
  a_deferred_addr: assert property (mem_req && !req_q && wreq_q && init_done
    |-> mem_addr == base_q + 24'h00_0018 + {19'h0, idx_q, 1'b0}) else $error("deferred address");
  a_deferred_answer: assert property (mem_ack && init_done |=> word_valid)
    else $error("deferred word not answered");
  a_mode_decode: assert property ($rose(init_done) |=> addr_ctrl_extract_disable == mode_q[8]
    && ext_control_filter_active == (mode_q[7] && !mode_q[8] && !promiscuous_receive))
    else $error("mode word decode wrong");
endmodule // hic_config_chk
bind hic_config hic_config_chk u_chk (.clk(clk), .rst(rst), .init_cmd(init_cmd),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .init_done(init_done), .word_req(word_req), .word_index(word_index),
  .word_valid(word_valid), .csr_wr(csr_wr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
  .modem_ready_in(modem_ready_in), .modem_ready_out(modem_ready_out),
  .modem_ready_oe(modem_ready_oe), .terminal_ready_in(terminal_ready_in),
  .terminal_ready_oe(terminal_ready_oe), .promiscuous_receive(promiscuous_receive),
  .ext_control_filter_active(ext_control_filter_active),
  .addr_ctrl_extract_disable(addr_ctrl_extract_disable));
`default_nettype wire

// ### tb/hic_config_tb.sv
// self-checking bench for the config block
`timescale 1ns/1ps
`default_nettype none
module hic_config_tb;
  import hic_pkg::*;
  localparam logic [23:0] BASE = 24'h01_2340; // block base, any even value
  // entries 1 to 3 clear extract disable; entries 0 and 4 keep it set, entry 4 alongside its address filter bit
  localparam logic [15:0] MODES [5] = '{16'h0100, 16'h96C0, 16'h96C0, 16'h0880, 16'h817C};
  localparam logic PROMS [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam logic [5:0] FLAGS [5] = '{6'h02, 6'h0A, 6'h0A, 6'h01, 6'h3E};
  logic clk, rst, init_cmd, mem_req, mem_ack, init_done, word_req, word_valid, csr_wr;
  logic modem_ready_out, modem_ready_oe, terminal_ready_out, terminal_ready_oe;
  logic promiscuous_receive, rts_cts_mode, tx_frame_end, tx_flag_sent, tx_start_ok;
  logic ext_control_filter_active, ext_address_filter_active, ctrl_two_octets;
  logic addr_two_octets, addr_ctrl_extract_disable, rx_check_disable, tx_check_disable;
  logic check_width_select, slow, mr_drv, tr_drv;
  logic [23:0] init_block_base, mem_addr;
  logic [15:0] mem_rdata, word_data, param_data, mode;
  logic [3:0] word_index, param_sel, csr_wdata, csr_rdata;
  logic [5:0] min_flag_count;
  logic [2:0] loopback_select;
  int n_fail, checks, cyc;
  // pin level: our drive unless the block drives it
  wire mr_pin = modem_ready_oe ? modem_ready_out : mr_drv;
  wire tr_pin = terminal_ready_oe ? terminal_ready_out : tr_drv;
  hic_config u_dut (.clk(clk), .rst(rst), .init_cmd(init_cmd), .init_block_base(init_block_base),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .init_done(init_done), .word_req(word_req), .word_index(word_index),
    .word_valid(word_valid), .word_data(word_data), .param_sel(param_sel),
    .param_data(param_data), .csr_wr(csr_wr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
    .modem_ready_in(mr_pin), .modem_ready_out(modem_ready_out), .modem_ready_oe(modem_ready_oe),
    .terminal_ready_in(tr_pin), .terminal_ready_out(terminal_ready_out),
    .terminal_ready_oe(terminal_ready_oe), .promiscuous_receive(promiscuous_receive),
    .rts_cts_mode(rts_cts_mode), .tx_frame_end(tx_frame_end), .tx_flag_sent(tx_flag_sent),
    .tx_start_ok(tx_start_ok), .min_flag_count(min_flag_count),
    .ext_control_filter_active(ext_control_filter_active),
    .ext_address_filter_active(ext_address_filter_active), .ctrl_two_octets(ctrl_two_octets),
    .addr_two_octets(addr_two_octets), .addr_ctrl_extract_disable(addr_ctrl_extract_disable),
    .rx_check_disable(rx_check_disable), .tx_check_disable(tx_check_disable),
    .check_width_select(check_width_select), .loopback_select(loopback_select));
  hic_mem_model u_mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
    .base(BASE), .mode(mode), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic csr(input logic [3:0] v);
    csr_wdata = v;
    csr_wr = 1'b1;
    tick(1);
    csr_wr = 1'b0;
  endtask
  task automatic flags(input int n);
    tx_flag_sent = 1'b1;
    tick(n);
    tx_flag_sent = 1'b0;
  endtask
  // init command; when stalling, a second command with another base lands mid-fetch
  task automatic do_init(input logic [15:0] m, input logic s);
    int k;
    mode = m;
    slow = s;
    init_cmd = 1'b1;
    tick(1);
    init_cmd = 1'b0;
    if (s) begin
      tick(3);
      init_block_base = BASE ^ 24'h00_0100;
      init_cmd = 1'b1;
      tick(1);
      init_cmd = 1'b0;
      init_block_base = BASE;
    end
    k = 0;
    while (init_done !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    chk(init_done, 1'b1);
    tick(2);
  endtask
  task automatic t_early();
    word_req = 1'b1;
    tick(1);
    word_req = 1'b0;
    tick(3);
    chk(mem_req, 1'b0);
    $display("early request test done");
  endtask
  task automatic t_eager();
    do_init(16'h0100, 1'b1);
    for (int i = 0; i < 12; i++) begin
      param_sel = 4'(i);
      tick(1);
      chk(param_data, i == 0 ? 16'h0100 : {8'hA5, 3'h0, 4'(i), 1'b0});
    end
    $display("eager fetch test done");
  endtask
  task automatic t_deferred();
    int k;
    for (int i = 0; i < 12; i++) begin
      word_index = 4'(i);
      word_req = 1'b1;
      tick(1);
      word_req = 1'b0;
      k = 0;
      while (word_valid !== 1'b1 && k < 50) begin
        tick(1);
        k++;
      end
      chk(word_data, {8'hA5, 8'(24 + 2 * i)});
      tick(1);
    end
    $display("deferred fetch test done");
  endtask
  task automatic t_modes();
    logic [15:0] m;
    for (int e = 0; e < 5; e++) begin
      m = MODES[e];
      promiscuous_receive = PROMS[e];
      do_init(m, 1'b0);
      chk(min_flag_count, FLAGS[e]);
      chk(addr_ctrl_extract_disable, m[8]);
      chk(ext_control_filter_active, m[7] & ~m[8] & ~PROMS[e]);
      chk(ext_address_filter_active, m[6] & ~m[8] & ~PROMS[e]);
      chk(ctrl_two_octets, m[10] & m[7] & ~m[8] & ~PROMS[e]);
      chk(addr_two_octets, m[9] & m[6] & ~m[8] & ~PROMS[e]);
      chk({rx_check_disable, tx_check_disable, check_width_select, loopback_select}, m[5:0]);
    end
    promiscuous_receive = 1'b0;
    $display("mode decode test done");
  endtask
  task automatic t_modem();
    csr(4'h0);
    mr_drv = 1'b1;
    tick(4);
    chk({modem_ready_oe, terminal_ready_oe, csr_rdata}, 6'h01);
    mr_drv = 1'b0;
    tr_drv = 1'b1;
    tick(4);
    chk(csr_rdata, 4'h2);
    csr(4'hD);
    chk({modem_ready_oe, modem_ready_out, terminal_ready_oe, terminal_ready_out}, 4'hE);
    tick(4);
    chk(csr_rdata, 4'hD);
    tr_drv = 1'b0;
    csr(4'h6);
    tick(4);
    chk({modem_ready_oe, modem_ready_out, csr_rdata}, 6'h24);
    csr(4'h0);
    $display("modem pin test done");
  endtask
  task automatic t_spacing();
    do_init(16'h9100, 1'b0);
    tx_frame_end = 1'b1;
    tick(1);
    tx_frame_end = 1'b0;
    chk(tx_start_ok, 1'b0);
    flags(9);
    chk(tx_start_ok, 1'b0);
    flags(1);
    chk(tx_start_ok, 1'b1);
    rts_cts_mode = 1'b1;
    mr_drv = 1'b1;
    tick(4);
    mr_drv = 1'b0;
    tick(4);
    chk(tx_start_ok, 1'b0);
    flags(8);
    chk(tx_start_ok, 1'b0);
    flags(1);
    chk(tx_start_ok, 1'b1);
    $display("flag spacing test done");
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    {init_cmd, word_req, csr_wr, promiscuous_receive, rts_cts_mode} = '0;
    {tx_frame_end, tx_flag_sent, slow, mr_drv, tr_drv} = '0;
    init_block_base = BASE;
    mode = 16'h0100;
    {word_index, param_sel, csr_wdata} = '0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    tick(5);
    chk({init_done, mem_req, modem_ready_oe, addr_ctrl_extract_disable, min_flag_count}, 10'h042);
    rst = 1'b0;
    t_early();
    t_eager();
    t_deferred();
    t_modes();
    t_modem();
    t_spacing();
    close_out();
  end
endmodule // hic_config_tb
`default_nettype wire

// ### tb/hic_mem_model.sv
// host memory model holding the init block and answering word reads
`timescale 1ns/1ps
`default_nettype none
module hic_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic [23:0] base,
  input wire logic [15:0] mode,
  input wire logic slow,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [1:0] wait_n; // cycles spent on the current word
  logic [23:0] ofs; // byte offset inside the block
  logic [15:0] word; // word stored at the requested place
  // mode at +0, every other word carries its own offset so misplaced reads show
  always_comb begin
    ofs = mem_addr - base;
    word = (ofs == 24'h00_0000) ? mode : {8'hA5, ofs[7:0]};
    // data only valid with ack; otherwise inverted so stale reads never match
    mem_rdata = mem_ack ? word : ~word;
  end
  // ack after one cycle, or after three when stalling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_n <= 2'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_n <= 2'h0;
    end else if (mem_req) begin
      if (wait_n >= (slow ? 2'h2 : 2'h0)) mem_ack <= 1'b1;
      else wait_n <= wait_n + 2'h1;
    end
  end
endmodule // hic_mem_model
`default_nettype wire
